// >>> include/drop_capture_cfg.svh
// register map, field positions, reset values and encodings of the drop event capture block
`ifndef DROP_CAPTURE_CFG_SVH
`define DROP_CAPTURE_CFG_SVH

`define DC_ADDR_W 16
`define DC_DATA_W 32

`define DC_MASK_OFS 16'h1C20
`define DC_PEND_OFS 16'h1C21
`define DC_EVT_STAT_OFS 16'h1C22
`define DC_EVT_EN_OFS 16'h1C23
`define DC_LOST_CNT_OFS 16'h1C24

`define DC_MASK_BIT 0
`define DC_MASK_RST 1'h1

`define DC_A_VALID_BIT 0
`define DC_A_PORT_LSB 1
`define DC_A_REASON_LSB 3
`define DC_B_VALID_BIT 7
`define DC_B_PORT_LSB 8
`define DC_B_REASON_LSB 10

`define DC_REASON_W 4
`define DC_PORT_W 2
`define DC_LEN_W 11
`define DC_MIN_ERR_LEN 11'h040

`define DC_PORT_RSVD 2'h3

`define DC_EVT_W 3
`define DC_EVT_CAPTURED 0
`define DC_EVT_LOST 1
`define DC_EVT_BAD_PORT 2
`define DC_EVT_EN_RST 3'h0

`define DC_LOST_W 16
`define DC_LOST_MAX 16'hFFFF

`endif

// >>> include/drop_capture_pkg.sv
// types shared by the drop event capture block
package drop_capture_pkg;

  typedef enum logic [3:0] {
    REASON_BCAST_LEVEL = 4'h0,
    REASON_RED = 4'h1,
    REASON_NO_BUFFER = 4'h2,
    REASON_NO_DESCRIPTOR = 4'h3,
    REASON_NO_DEST_PORT = 4'h4,
    REASON_RX_ERROR = 4'h5,
    REASON_BUFFER_LEVEL = 4'h6,
    REASON_YELLOW_RANDOM = 4'h9
  } drop_reason_t;

  typedef enum logic [1:0] {
    PORT_EXT_MII = 2'h0,
    PORT_SWITCH_1 = 2'h1,
    PORT_SWITCH_2 = 2'h2
  } src_port_t;

  typedef enum logic [2:0] {
    SLOT_EMPTY = 3'b001,
    SLOT_A_HELD = 3'b010,
    SLOT_BOTH_HELD = 3'b100
  } slot_state_t;

endpackage

// >>> src/drop_reason_encoder.sv
// turns the buffer manager drop causes into one drop reason code
`timescale 1ns/100ps
`default_nettype none
`include "drop_capture_cfg.svh"

module drop_reason_encoder (
  input wire logic no_buffer,
  input wire logic no_descriptor,
  input wire logic buffer_level_over,
  input wire logic dest_unknown,
  input wire logic bcast_level_over,
  input wire logic no_dest_port,
  input wire logic rx_error,
  input wire logic [`DC_LEN_W-1:0] frame_len,
  input wire logic red_drop_en,
  input wire logic pkt_red,
  input wire logic yellow_drop_en,
  input wire logic pkt_yellow_picked,
  output logic hit,
  output logic [`DC_REASON_W-1:0] reason
);

  // fixed priority: resource shortage first, then lookup, errors, rate limiting
  always_comb begin
    hit = 1'b1;
    reason = drop_capture_pkg::REASON_NO_BUFFER;
    if (no_buffer) begin
      reason = drop_capture_pkg::REASON_NO_BUFFER;
    end else if (no_descriptor) begin
      reason = drop_capture_pkg::REASON_NO_DESCRIPTOR;
    end else if (buffer_level_over) begin
      reason = drop_capture_pkg::REASON_BUFFER_LEVEL;
    end else if (dest_unknown && bcast_level_over) begin
      reason = drop_capture_pkg::REASON_BCAST_LEVEL;
    end else if (dest_unknown && no_dest_port) begin
      reason = drop_capture_pkg::REASON_NO_DEST_PORT;
    end else if (rx_error && (frame_len > `DC_MIN_ERR_LEN)) begin
      reason = drop_capture_pkg::REASON_RX_ERROR;
    end else if (red_drop_en && pkt_red) begin
      reason = drop_capture_pkg::REASON_RED;
    end else if (yellow_drop_en && pkt_yellow_picked) begin
      reason = drop_capture_pkg::REASON_YELLOW_RANDOM;
    end else begin
      hit = 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> src/switch_drop_event_capture.sv
// drop event capture: two-slot pending status, mask, event status and interrupt
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "drop_capture_cfg.svh"

module switch_drop_event_capture (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`DC_ADDR_W-1:0] reg_addr,
  input wire logic [`DC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`DC_DATA_W-1:0] reg_rdata,
  input wire logic drop_strobe,
  input wire logic [`DC_PORT_W-1:0] drop_port,
  input wire logic drop_no_buffer,
  input wire logic drop_no_descriptor,
  input wire logic drop_buffer_level_over,
  input wire logic drop_dest_unknown,
  input wire logic drop_bcast_level_over,
  input wire logic drop_no_dest_port,
  input wire logic drop_rx_error,
  input wire logic [`DC_LEN_W-1:0] drop_frame_len,
  input wire logic rl_red_drop_en,
  input wire logic rl_pkt_red,
  input wire logic rl_yellow_drop_en,
  input wire logic rl_pkt_yellow_picked,
  output logic drop_irq
);

  // ==========================================================
  // register decode
  // ==========================================================
  logic sel_mask;
  logic sel_pend;
  logic sel_evt_stat;
  logic sel_evt_en;
  logic sel_lost;
  logic pend_rd;
  logic lost_rd;
  logic mask_wr;
  logic evt_stat_wr;
  logic evt_en_wr;

  assign sel_mask = (reg_addr == `DC_MASK_OFS);
  assign sel_pend = (reg_addr == `DC_PEND_OFS);
  assign sel_evt_stat = (reg_addr == `DC_EVT_STAT_OFS);
  assign sel_evt_en = (reg_addr == `DC_EVT_EN_OFS);
  assign sel_lost = (reg_addr == `DC_LOST_CNT_OFS);
  assign pend_rd = reg_rd && sel_pend;
  assign lost_rd = reg_rd && sel_lost;
  assign mask_wr = reg_wr && sel_mask;
  assign evt_stat_wr = reg_wr && sel_evt_stat;
  assign evt_en_wr = reg_wr && sel_evt_en;

  // ==========================================================
  // drop cause encoding
  // ==========================================================
  logic enc_hit;
  logic [`DC_REASON_W-1:0] enc_reason;

  drop_reason_encoder u_encoder (
    .no_buffer(drop_no_buffer),
    .no_descriptor(drop_no_descriptor),
    .buffer_level_over(drop_buffer_level_over),
    .dest_unknown(drop_dest_unknown),
    .bcast_level_over(drop_bcast_level_over),
    .no_dest_port(drop_no_dest_port),
    .rx_error(drop_rx_error),
    .frame_len(drop_frame_len),
    .red_drop_en(rl_red_drop_en),
    .pkt_red(rl_pkt_red),
    .yellow_drop_en(rl_yellow_drop_en),
    .pkt_yellow_picked(rl_pkt_yellow_picked),
    .hit(enc_hit),
    .reason(enc_reason)
  );

  // ports 0 (external MII), 1 and 2 are legal; code 3 is reserved
  function automatic logic port_legal(input logic [`DC_PORT_W-1:0] p);
    port_legal = (p != `DC_PORT_RSVD);
  endfunction

  logic drop_evt;
  logic bad_port_evt;

  assign drop_evt = drop_strobe && enc_hit && port_legal(drop_port);
  assign bad_port_evt = drop_strobe && enc_hit && !port_legal(drop_port);

  // ==========================================================
  // capture slots
  // ==========================================================
  drop_capture_pkg::slot_state_t state_r;
  drop_capture_pkg::slot_state_t state_nxt;
  drop_capture_pkg::slot_state_t state_base;
  logic a_valid_r;
  logic a_valid_nxt;
  logic [`DC_REASON_W-1:0] a_reason_r;
  logic [`DC_REASON_W-1:0] a_reason_nxt;
  logic [`DC_PORT_W-1:0] a_port_r;
  logic [`DC_PORT_W-1:0] a_port_nxt;
  logic b_valid_r;
  logic b_valid_nxt;
  logic [`DC_REASON_W-1:0] b_reason_r;
  logic [`DC_REASON_W-1:0] b_reason_nxt;
  logic [`DC_PORT_W-1:0] b_port_r;
  logic [`DC_PORT_W-1:0] b_port_nxt;
  logic captured;
  logic lost;

  // a read clears first, then a drop in the same cycle is caught in slot A
  always_comb begin
    state_base = pend_rd ? drop_capture_pkg::SLOT_EMPTY : state_r;
    state_nxt = state_base;
    a_valid_nxt = pend_rd ? 1'b0 : a_valid_r;
    a_reason_nxt = pend_rd ? '0 : a_reason_r;
    a_port_nxt = pend_rd ? '0 : a_port_r;
    b_valid_nxt = pend_rd ? 1'b0 : b_valid_r;
    b_reason_nxt = pend_rd ? '0 : b_reason_r;
    b_port_nxt = pend_rd ? '0 : b_port_r;
    captured = 1'b0;
    lost = 1'b0;
    if (drop_evt) begin
      unique case (state_base)
        drop_capture_pkg::SLOT_EMPTY: begin
          a_valid_nxt = 1'b1;
          a_reason_nxt = enc_reason;
          a_port_nxt = drop_port;
          state_nxt = drop_capture_pkg::SLOT_A_HELD;
          captured = 1'b1;
        end
        drop_capture_pkg::SLOT_A_HELD: begin
          b_valid_nxt = 1'b1;
          b_reason_nxt = enc_reason;
          b_port_nxt = drop_port;
          state_nxt = drop_capture_pkg::SLOT_BOTH_HELD;
          captured = 1'b1;
        end
        drop_capture_pkg::SLOT_BOTH_HELD: begin
          lost = 1'b1;
        end
        default: begin
          state_nxt = drop_capture_pkg::SLOT_EMPTY;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= drop_capture_pkg::SLOT_EMPTY;
    end else begin
      state_r <= state_nxt;
    end
  end

  // status fields update whatever the mask bit holds
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      a_valid_r <= 1'b0;
      a_reason_r <= '0;
      a_port_r <= '0;
    end else begin
      a_valid_r <= a_valid_nxt;
      a_reason_r <= a_reason_nxt;
      a_port_r <= a_port_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      b_valid_r <= 1'b0;
      b_reason_r <= '0;
      b_port_r <= '0;
    end else begin
      b_valid_r <= b_valid_nxt;
      b_reason_r <= b_reason_nxt;
      b_port_r <= b_port_nxt;
    end
  end

  // ==========================================================
  // mask register
  // ==========================================================
  logic mask_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_r <= `DC_MASK_RST;
    end else if (mask_wr) begin
      mask_r <= reg_wdata[`DC_MASK_BIT];
    end
  end

  // ==========================================================
  // event status, enable and lost counter
  // ==========================================================
  logic [`DC_EVT_W-1:0] evt_status_r;
  logic [`DC_EVT_W-1:0] evt_enable_r;
  logic [`DC_EVT_W-1:0] evt_set;
  logic [`DC_LOST_W-1:0] lost_cnt_r;

  assign evt_set = {bad_port_evt, lost, captured};

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      evt_status_r <= '0;
    end else if (evt_stat_wr) begin
      evt_status_r <= (evt_status_r & ~reg_wdata[`DC_EVT_W-1:0]) | evt_set;
    end else begin
      evt_status_r <= evt_status_r | evt_set;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      evt_enable_r <= `DC_EVT_EN_RST;
    end else if (evt_en_wr) begin
      evt_enable_r <= reg_wdata[`DC_EVT_W-1:0];
    end
  end

  // saturating count of drops refused while both slots are full
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lost_cnt_r <= '0;
    end else if (lost_rd) begin
      lost_cnt_r <= lost ? {{(`DC_LOST_W-1){1'b0}}, 1'b1} : '0;
    end else if (lost && (lost_cnt_r != `DC_LOST_MAX)) begin
      lost_cnt_r <= lost_cnt_r + 1'b1;
    end
  end

  // ==========================================================
  // interrupt
  // ==========================================================
  logic irq_r;
  logic pend_irq;
  logic evt_irq;

  assign pend_irq = (a_valid_r || b_valid_r) && !mask_r;
  assign evt_irq = |(evt_status_r & evt_enable_r);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= pend_irq || evt_irq;
    end
  end

  assign drop_irq = irq_r;

  // ==========================================================
  // pending word layout
  // ==========================================================
  // places both slots at their field positions; reserved bits stay zero
  function automatic logic [`DC_DATA_W-1:0] pack_pending(
    input logic av,
    input logic [`DC_PORT_W-1:0] ap,
    input logic [`DC_REASON_W-1:0] ar,
    input logic bv,
    input logic [`DC_PORT_W-1:0] bp,
    input logic [`DC_REASON_W-1:0] br
  );
    logic [`DC_DATA_W-1:0] w;
    w = '0;
    w[`DC_A_VALID_BIT] = av;
    w[`DC_A_PORT_LSB +: `DC_PORT_W] = ap;
    w[`DC_A_REASON_LSB +: `DC_REASON_W] = ar;
    w[`DC_B_VALID_BIT] = bv;
    w[`DC_B_PORT_LSB +: `DC_PORT_W] = bp;
    w[`DC_B_REASON_LSB +: `DC_REASON_W] = br;
    return w;
  endfunction

  // ==========================================================
  // read data
  // ==========================================================
  logic [`DC_DATA_W-1:0] rd_data_r;
  logic [`DC_DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    if (sel_mask) begin
      rd_mux[`DC_MASK_BIT] = mask_r;
    end else if (sel_pend) begin
      rd_mux = pack_pending(a_valid_r, a_port_r, a_reason_r, b_valid_r, b_port_r, b_reason_r);
    end else if (sel_evt_stat) begin
      rd_mux[`DC_EVT_W-1:0] = evt_status_r;
    end else if (sel_evt_en) begin
      rd_mux[`DC_EVT_W-1:0] = evt_enable_r;
    end else if (sel_lost) begin
      rd_mux[`DC_LOST_W-1:0] = lost_cnt_r;
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data_r <= '0;
    end else if (reg_rd) begin
      rd_data_r <= rd_mux;
    end else begin
      rd_data_r <= '0;
    end
  end

  assign reg_rdata = rd_data_r;

endmodule
`default_nettype wire

// >>> testbench/drop_capture_chk.sv
// concurrent checks on the drop event capture block ports
`timescale 1ns/100ps
`default_nettype none
`include "drop_capture_cfg.svh"
module drop_capture_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`DC_ADDR_W-1:0] reg_addr,
  input wire logic [`DC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`DC_DATA_W-1:0] reg_rdata,
  input wire logic drop_strobe,
  input wire logic [`DC_PORT_W-1:0] drop_port,
  input wire logic drop_no_buffer,
  input wire logic drop_irq
);
  logic mask_r;
  logic [2:0] en_r;
  // ==========================================
  // shadow of mask and event enable
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_r <= `DC_MASK_RST;
      en_r <= `DC_EVT_EN_RST;
    end else if (reg_wr && reg_addr == `DC_MASK_OFS) begin
      mask_r <= reg_wdata[0];
    end else if (reg_wr && reg_addr == `DC_EVT_EN_OFS) begin
      en_r <= reg_wdata[2:0];
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence pend_rd;
    reg_rd && reg_addr == `DC_PEND_OFS;
  endsequence
  sequence nb_drop;
    drop_strobe && drop_no_buffer && drop_port != 2'h3;
  endsequence
  a_mask_gates_irq: assert property (
    mask_r && en_r == 3'h0 |=> !drop_irq) else $error("irq while masked");
  a_irq_on_drop: assert property (
    nb_drop ##0 !mask_r ##1 !mask_r |=> drop_irq) else $error("irq missing");
  a_irq_falls_read: assert property (
    pend_rd ##0 (!drop_strobe && en_r == 3'h0) ##1 en_r == 3'h0 |=> !drop_irq)
    else $error("irq stuck");
  a_mask_reads_back: assert property (
    reg_rd && reg_addr == `DC_MASK_OFS |=> reg_rdata == 32'(mask_r))
    else $error("mask readback");
  a_b_after_a: assert property (
    pend_rd |=> !reg_rdata[`DC_B_VALID_BIT] || reg_rdata[`DC_A_VALID_BIT])
    else $error("slot b without a");
  a_pend_fields_legal: assert property (
    pend_rd |=> reg_rdata[31:14] == 18'h0 && reg_rdata[2:1] != 2'h3
    && reg_rdata[9:8] != 2'h3) else $error("pending field illegal");
  a_pend_read_clears: assert property (
    pend_rd ##0 !drop_strobe ##1 !drop_strobe ##1 pend_rd |=> reg_rdata == 32'h0)
    else $error("pending not cleared");
  a_slot_a_fill: assert property (
    pend_rd ##0 nb_drop ##1 (!drop_strobe && !reg_rd) ##1 pend_rd
    |=> reg_rdata == 32'({4'h2, $past(drop_port, 3), 1'b1})) else $error("slot a");
endmodule
bind switch_drop_event_capture drop_capture_chk u_chk (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .drop_strobe(drop_strobe), .drop_port(drop_port),
  .drop_no_buffer(drop_no_buffer), .drop_irq(drop_irq));
`default_nettype wire

// >>> testbench/switch_drop_event_capture_tb.sv
// self-checking bench for the drop event capture block
`timescale 1ns/100ps
`default_nettype none
`include "drop_capture_cfg.svh"
module switch_drop_event_capture_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] reg_addr = 16'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic drop_strobe = 1'b0;
  logic [1:0] drop_port = 2'h0;
  logic [10:0] cv = 11'h0;
  logic [10:0] fl = 11'h0;
  logic drop_irq;
  logic [31:0] rng = 32'h0000F5E4;
  int err_count = 0;
  int samples_checked = 0;
  int i;
  logic [10:0] c;
  logic [10:0] l;
  logic [1:0] p;
  logic [4:0] e;
  logic [31:0] x;
  // one corner per cause, a lone enable, and an error frame of exactly 64 bytes
  logic [10:0] tbl [10] = '{11'h001, 11'h002, 11'h004, 11'h018, 11'h028,
                            11'h040, 11'h180, 11'h600, 11'h080, 11'h040};
  switch_drop_event_capture DUT (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .drop_strobe(drop_strobe), .drop_port(drop_port),
    .drop_no_buffer(cv[0]), .drop_no_descriptor(cv[1]),
    .drop_buffer_level_over(cv[2]), .drop_dest_unknown(cv[3]),
    .drop_bcast_level_over(cv[4]), .drop_no_dest_port(cv[5]),
    .drop_rx_error(cv[6]), .drop_frame_len(fl), .rl_red_drop_en(cv[7]),
    .rl_pkt_red(cv[8]), .rl_yellow_drop_en(cv[9]),
    .rl_pkt_yellow_picked(cv[10]), .drop_irq(drop_irq));
  // ==========================================
  // clock and helpers
  initial begin
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  // returns {captured, reason} by cause priority
  function automatic logic [4:0] exp_r(input logic [10:0] k, input logic [10:0] n);
    if (k[0]) return 5'h12;
    if (k[1]) return 5'h13;
    if (k[2]) return 5'h16;
    if (k[3] && k[4]) return 5'h10;
    if (k[3] && k[5]) return 5'h14;
    if (k[6] && n > 11'h040) return 5'h15;
    if (k[7] && k[8]) return 5'h11;
    if (k[9] && k[10]) return 5'h19;
    return 5'h00;
  endfunction
  task tally_and_finish;
    if (err_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // last low leaves the strobe up so the next drop follows back to back
  task drop(input logic [10:0] k, input logic [10:0] n, input logic [1:0] q, input bit last);
    @(posedge clk);
    drop_strobe <= 1'b1;
    cv <= k;
    fl <= n;
    drop_port <= q;
    if (last) begin
      @(posedge clk);
      drop_strobe <= 1'b0;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    tally_and_finish;
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    #1 chk(32'(drop_irq), 32'h0);
    rd(`DC_MASK_OFS, 32'h1);
    rd(`DC_PEND_OFS, 32'h0);
    for (i = 0; i < 48; i++) begin
      rng = xs(rng);
      c = (i < 10) ? tbl[i] : rng[10:0] & rng[21:11];
      l = (i == 9) ? 11'h040 : (i < 9) ? 11'h041 : rng[31:21];
      p = (rng[23:22] == 2'h3) ? 2'h1 : rng[23:22];
      e = exp_r(c, l);
      drop(c, l, p, 1'b1);
      x = e[4] ? 32'({e[3:0], p, 1'b1}) : 32'h0;
      rd(`DC_PEND_OFS, x);
      chk(32'(drop_irq), 32'h0);
    end
    wr(`DC_MASK_OFS, 32'h0);
    rd(`DC_MASK_OFS, 32'h0);
    drop(11'h001, 11'h041, 2'h0, 1'b1);
    repeat (2) @(posedge clk);
    #1 chk(32'(drop_irq), 32'h1);
    wr(`DC_MASK_OFS, 32'h1);
    @(posedge clk);
    #1 chk(32'(drop_irq), 32'h0);
    rd(`DC_PEND_OFS, 32'h11);
    fork
      drop(11'h001, 11'h041, 2'h2, 1'b1);
      rd(`DC_PEND_OFS, 32'h0);
    join
    rd(`DC_PEND_OFS, 32'h15);
    wr(`DC_EVT_STAT_OFS, 32'h7);
    drop(11'h001, 11'h041, 2'h1, 1'b0);
    drop(11'h180, 11'h041, 2'h2, 1'b0);
    drop(11'h002, 11'h041, 2'h0, 1'b1);
    rd(`DC_PEND_OFS, 32'h0693);
    rd(`DC_PEND_OFS, 32'h0);
    rd(`DC_LOST_CNT_OFS, 32'h1);
    rd(`DC_LOST_CNT_OFS, 32'h0);
    drop(11'h001, 11'h041, 2'h3, 1'b1);
    rd(`DC_PEND_OFS, 32'h0);
    wr(`DC_EVT_STAT_OFS, 32'h1);
    rd(`DC_EVT_STAT_OFS, 32'h6);
    wr(16'h1C25, 32'hFFFFFFFF);
    rd(16'h1C25, 32'h0);
    rd(`DC_MASK_OFS, 32'h1);
    wr(`DC_EVT_EN_OFS, 32'h4);
    rd(`DC_EVT_EN_OFS, 32'h4);
    chk(32'(drop_irq), 32'h1);
    wr(`DC_EVT_STAT_OFS, 32'h4);
    @(posedge clk);
    #1 chk(32'(drop_irq), 32'h0);
    wr(`DC_MASK_OFS, 32'h0);
    drop(11'h001, 11'h041, 2'h1, 1'b1);
    @(posedge clk);
    #1 chk(32'(drop_irq), 32'h1);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1 chk(32'(drop_irq), 32'h0);
    rd(`DC_MASK_OFS, 32'h1);
    rd(`DC_PEND_OFS, 32'h0);
    rd(`DC_EVT_EN_OFS, 32'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
